// ==== rate_gen_pkg.sv ====
// Constants and helpers shared by the baud rate generator files
package rate_gen_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int DIVISOR_WIDTH  = 16;
   localparam int BYTE_WIDTH     = 8;
   localparam int PRESCALE_WIDTH = 7;
   localparam int VOTE_WIDTH     = 3;

   // ------------------------------------------------------------
   // Reset value and other constants
   // ------------------------------------------------------------
   localparam logic [DIVISOR_WIDTH-1:0]  DIVISOR_RESET  = 16'h0000;
   localparam logic [DIVISOR_WIDTH-1:0]  COUNT_ONE      = 16'h0001;
   localparam logic [BYTE_WIDTH-1:0]     HIGH_BYTE_ZERO = 8'h00;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ONE   = 7'h01;

   // ------------------------------------------------------------
   // Divide factors applied after the divisor timer
   // ------------------------------------------------------------
   localparam logic [PRESCALE_WIDTH-1:0] FACTOR_ASYNC_SLOW = 7'h40;
   localparam logic [PRESCALE_WIDTH-1:0] FACTOR_ASYNC_FAST = 7'h10;
   localparam logic [PRESCALE_WIDTH-1:0] FACTOR_SYNC       = 7'h04;

   // ------------------------------------------------------------
   // Receive voting
   // ------------------------------------------------------------
   localparam logic [1:0] SAMPLE_LAST = 2'h2;
   localparam logic [1:0] SAMPLE_ONE  = 2'h1;

   // Last prescale count before a bit tick
   function automatic logic [PRESCALE_WIDTH-1:0] prescale_limit(
      input logic sync_mode,
      input logic wide_sel,
      input logic high_sel);
      logic [PRESCALE_WIDTH-1:0] factor;
      // Async with both selects set shares the sync factor
      factor = FACTOR_SYNC;
      if (!sync_mode) begin
         if (!wide_sel && !high_sel) begin
            factor = FACTOR_ASYNC_SLOW;
         end else if (wide_sel ^ high_sel) begin
            factor = FACTOR_ASYNC_FAST;
         end
      end
      return factor - PRESCALE_ONE;
   endfunction

   function automatic logic majority(input logic [VOTE_WIDTH-1:0] s);
      return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

endpackage

// ==== sample_if.sv ====
// Carrier between the rate timer and the receive voter
`timescale 1ns/1ps
interface sample_if;
   logic strobe;
   logic pin;
   logic clear;
   logic level;
   logic valid;

   modport source (output strobe, output pin, output clear,
                   input level, input valid);
   modport voter  (input strobe, input pin, input clear,
                   output level, output valid);
endinterface

// ==== receive_majority_voter.sv ====
// Three-sample majority vote of the receive pin
`timescale 1ns/1ps
module receive_majority_voter (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   sample_if.voter   smp
);

   logic [rate_gen_pkg::VOTE_WIDTH-1:0] shift_q, shift_d;
   logic [1:0]                          count_q, count_d;
   logic                                level_q, level_d;
   logic                                valid_q, valid_d;

   // ------------------------------------------------------------
   // Voting
   // ------------------------------------------------------------
   always_comb begin
      shift_d = shift_q;
      count_d = count_q;
      level_d = level_q;
      valid_d = 1'b0;
      if (smp.clear) begin
         count_d = '0;
      end else if (smp.strobe) begin
         shift_d = {shift_q[1:0], smp.pin};
         if (count_q == rate_gen_pkg::SAMPLE_LAST) begin
            count_d = '0;
            valid_d = 1'b1;
            level_d = rate_gen_pkg::majority(shift_d);
         end else begin
            count_d = count_q + rate_gen_pkg::SAMPLE_ONE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= '1;
         count_q <= '0;
         level_q <= 1'b1;
         valid_q <= 1'b0;
      end else begin
         shift_q <= shift_d;
         count_q <= count_d;
         level_q <= level_d;
         valid_q <= valid_d;
      end
   end

   assign smp.level = level_q;
   assign smp.valid = valid_q;

   AST_VOTE_MAJORITY: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      valid_q |-> level_q == rate_gen_pkg::majority(shift_q))
      else $error("voted level differs from majority of samples");

   AST_THIRD_SAMPLE: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      valid_q |-> $past(count_q) == rate_gen_pkg::SAMPLE_LAST)
      else $error("vote issued before three samples");

endmodule // receive_majority_voter

// ==== serial_baud_rate_generator.sv ====
// Baud rate generator: divisor timer, rate prescaler and receive sampling
`timescale 1ns/1ps
module serial_baud_rate_generator (
   input  wire logic                                 sys_clk,
   input  wire logic                                 reset_n,
   input  wire logic [rate_gen_pkg::BYTE_WIDTH-1:0]  write_data,
   input  wire logic                                 divisor_low_write,
   input  wire logic                                 divisor_high_write,
   input  wire logic                                 wide_counter_select,
   input  wire logic                                 high_speed_select,
   input  wire logic                                 sync_mode,
   input  wire logic                                 clock_master,
   input  wire logic                                 receive_pin,
   output logic                                      rate_tick_q,
   output logic                                      baud_tick_q,
   output logic                                      receive_level,
   output logic                                      receive_level_valid
);

   localparam int DW = rate_gen_pkg::DIVISOR_WIDTH;
   localparam int PW = rate_gen_pkg::PRESCALE_WIDTH;

   logic [DW-1:0] divisor_q, divisor_d;
   logic [DW-1:0] count_q, count_d;
   logic [PW-1:0] prescale_q, prescale_d;
   logic          rate_tick_d, baud_tick_d;
   logic [DW-1:0] limit;
   logic [PW-1:0] plimit, pmid;
   logic          divisor_write, run, wrap;

   sample_if smp ();

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   assign divisor_write = divisor_low_write | divisor_high_write;
   // Slave in sync mode takes its clock from outside
   assign run = !sync_mode || clock_master;
   assign limit = wide_counter_select ? divisor_q
                : {rate_gen_pkg::HIGH_BYTE_ZERO,
                   divisor_q[rate_gen_pkg::BYTE_WIDTH-1:0]};
   // High speed select has no effect once sync is set
   assign plimit = rate_gen_pkg::prescale_limit(sync_mode,
                      wide_counter_select, high_speed_select);
   assign pmid = plimit >> 1;
   // Compare with >= so a narrowed limit never strands the count
   assign wrap = count_q >= limit;

   // ------------------------------------------------------------
   // Divisor timer and prescaler
   // ------------------------------------------------------------
   always_comb begin
      divisor_d   = divisor_q;
      count_d     = count_q;
      prescale_d  = prescale_q;
      rate_tick_d = 1'b0;
      baud_tick_d = 1'b0;
      if (divisor_low_write) begin
         divisor_d[rate_gen_pkg::BYTE_WIDTH-1:0] = write_data;
      end
      if (divisor_high_write) begin
         divisor_d[DW-1:rate_gen_pkg::BYTE_WIDTH] = write_data;
      end
      if (divisor_write) begin
         count_d    = '0;
         prescale_d = '0;
      end else if (run) begin
         if (wrap) begin
            count_d     = '0;
            rate_tick_d = 1'b1;
            if (prescale_q >= plimit) begin
               prescale_d  = '0;
               baud_tick_d = 1'b1;
            end else begin
               prescale_d = prescale_q + rate_gen_pkg::PRESCALE_ONE;
            end
         end else begin
            // Counts core clock edges directly
            count_d = count_q + rate_gen_pkg::COUNT_ONE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         divisor_q   <= rate_gen_pkg::DIVISOR_RESET;
         count_q     <= '0;
         prescale_q  <= '0;
         rate_tick_q <= 1'b0;
         baud_tick_q <= 1'b0;
      end else begin
         divisor_q   <= divisor_d;
         count_q     <= count_d;
         prescale_q  <= prescale_d;
         rate_tick_q <= rate_tick_d;
         baud_tick_q <= baud_tick_d;
      end
   end

   // ------------------------------------------------------------
   // Receive sampling around the middle of each bit
   // ------------------------------------------------------------
   // Three consecutive timer ticks centred on the bit middle
   assign smp.strobe = run && !divisor_write && wrap &&
                       (prescale_q + rate_gen_pkg::PRESCALE_ONE >= pmid) &&
                       (prescale_q <= pmid + rate_gen_pkg::PRESCALE_ONE);
   assign smp.pin   = receive_pin;
   assign smp.clear = divisor_write;

   receive_majority_voter u_voter (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .smp     (smp.voter)
   );

   assign receive_level       = smp.level;
   assign receive_level_valid = smp.valid;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_quiet_at_limit;
      run && !divisor_write && count_q == limit;
   endsequence

   sequence s_tick_reload;
      rate_tick_q && count_q == '0;
   endsequence

   AST_WRITE_CLEARS: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      divisor_write |=> count_q == '0 && prescale_q == '0 && !rate_tick_q)
      else $error("divisor write did not clear the timer");

   AST_TICK_AT_LIMIT: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_quiet_at_limit |=> s_tick_reload)
      else $error("timer did not tick and reload at its limit");

   AST_NO_EARLY_TICK: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!divisor_write && count_q < limit) |=> !rate_tick_q)
      else $error("timer ticked before reaching the divisor");

   AST_NARROW_LIMIT: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !wide_counter_select |-> limit[DW-1:rate_gen_pkg::BYTE_WIDTH] == '0)
      else $error("high divisor byte used in 8-bit mode");

   AST_ASYNC_SLOW: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!sync_mode && !wide_counter_select && !high_speed_select)
      |-> plimit == 7'h3f)
      else $error("async slow mode not dividing by 64");

   AST_ASYNC_FAST: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!sync_mode && (wide_counter_select ^ high_speed_select))
      |-> plimit == 7'h0f)
      else $error("async one-bit mode not dividing by 16");

   AST_ASYNC_BOTH: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!sync_mode && wide_counter_select && high_speed_select)
      |-> plimit == 7'h03)
      else $error("async both-bit mode not dividing by 4");

   AST_SYNC_FACTOR: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      sync_mode |-> plimit == 7'h03)
      else $error("sync mode not dividing by 4");

   AST_SLAVE_QUIET: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (sync_mode && !clock_master) |=> !rate_tick_q && !baud_tick_q)
      else $error("ticks produced while clock slave");

   AST_ZERO_DIVISOR: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!sync_mode && !divisor_write && limit == '0)[*2] |=> rate_tick_q)
      else $error("zero divisor did not tick every clock");

   AST_BAUD_TICK: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      baud_tick_q |-> rate_tick_q && prescale_q == '0)
      else $error("bit tick without timer tick and prescale wrap");

   AST_LOW_BYTE_LOAD: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      divisor_low_write |=>
      divisor_q[rate_gen_pkg::BYTE_WIDTH-1:0] == $past(write_data))
      else $error("low divisor byte not loaded");

   AST_HIGH_BYTE_LOAD: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      divisor_high_write |=>
      divisor_q[DW-1:rate_gen_pkg::BYTE_WIDTH] == $past(write_data))
      else $error("high divisor byte not loaded");

   AST_DIVISOR_KEPT: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !divisor_write |=> $stable(divisor_q))
      else $error("divisor changed without a write");

   AST_SLAVE_FROZEN: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (sync_mode && !clock_master && !divisor_write)
      |=> $stable(count_q) && $stable(prescale_q))
      else $error("timer moved while clock slave");

   AST_WRITE_DROPS_VOTE: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      divisor_write |=> !receive_level_valid)
      else $error("vote issued right after a divisor write");

endmodule // serial_baud_rate_generator

// ==== serial_peer_model.sv ====
// Remote serial peer that drives the receive pin, optionally glitched
`timescale 1ns/1ps
module serial_peer_model (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic line_level,
   input  wire logic glitch_en,
   output logic      receive_pin
);
   logic [1:0] phase_q;
   // One bad cycle in three spoils exactly one of three back-to-back samples
   always @(negedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q     <= 2'h0;
         receive_pin <= 1'h1;
      end else begin
         phase_q     <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
         receive_pin <= line_level ^ (glitch_en && phase_q == 2'h0);
      end
   end
endmodule // serial_peer_model

// ==== testbench.sv ====
// Self-checking bench for the baud rate generator
`timescale 1ns/1ps
module testbench;
   logic                                sys_clk;
   logic                                reset_n;
   logic [rate_gen_pkg::BYTE_WIDTH-1:0] write_data;
   logic                                divisor_low_write;
   logic                                divisor_high_write;
   logic                                wide_counter_select;
   logic                                high_speed_select;
   logic                                sync_mode;
   logic                                clock_master;
   logic                                receive_pin;
   logic                                rate_tick_q;
   logic                                baud_tick_q;
   logic                                receive_level;
   logic                                receive_level_valid;
   logic                                line_level;
   logic                                glitch_en;
   int                                  num_errors;
   int                                  n_compared;
   int                                  cycle_count;

   serial_baud_rate_generator i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .write_data(write_data),
      .divisor_low_write(divisor_low_write),
      .divisor_high_write(divisor_high_write),
      .wide_counter_select(wide_counter_select),
      .high_speed_select(high_speed_select), .sync_mode(sync_mode),
      .clock_master(clock_master), .receive_pin(receive_pin),
      .rate_tick_q(rate_tick_q), .baud_tick_q(baud_tick_q),
      .receive_level(receive_level),
      .receive_level_valid(receive_level_valid));

   serial_peer_model i_peer (
      .sys_clk(sys_clk), .reset_n(reset_n), .line_level(line_level),
      .glitch_en(glitch_en), .receive_pin(receive_pin));

   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Whole run needs about 12000 cycles
   always @(posedge sys_clk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 40000) begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic report_and_stop;
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check_int(input int exp, input int act);
      n_compared++;
      if (exp != act) begin
         num_errors++;
         $display("mismatch t=%0t exp=%0h got=%0h", $time, exp, act);
      end
   endtask

   task automatic check_bit(input logic exp, input logic act);
      n_compared++;
      if (exp !== act) begin
         num_errors++;
         $display("mismatch t=%0t exp=%0h got=%0h", $time, exp, act);
      end
   endtask

   function automatic logic pick(input int which);
      if (which == 0) return rate_tick_q;
      if (which == 1) return baud_tick_q;
      return receive_level_valid;
   endfunction

   // Cycles between two pulses of the chosen output
   task automatic gap(input int which, output int n);
      int k;
      n = 0;
      k = 0;
      while (pick(which) !== 1'h1 && k < 20000) begin
         @(negedge sys_clk);
         k++;
      end
      do begin
         @(negedge sys_clk);
         n++;
      end while (pick(which) !== 1'h1 && n < 20000);
   endtask

   task automatic write_div(input logic [7:0] hi, input logic [7:0] lo);
      write_data         = hi;
      divisor_high_write = 1'h1;
      @(negedge sys_clk);
      write_data         = lo;
      divisor_high_write = 1'h0;
      divisor_low_write  = 1'h1;
      @(negedge sys_clk);
      divisor_low_write  = 1'h0;
   endtask

   task automatic run_case(input logic s, w, h, input logic [7:0] hi, lo,
                           input int rate_exp, baud_exp);
      int n;
      sync_mode           = s;
      wide_counter_select = w;
      high_speed_select   = h;
      clock_master        = 1'h1;
      write_div(hi, lo);
      gap(0, n);
      check_int(rate_exp, n);
      gap(1, n);
      check_int(baud_exp, n);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_slave;
      int cnt;
      sync_mode    = 1'h1;
      clock_master = 1'h0;
      write_div(8'h00, 8'h02);
      cnt = 0;
      repeat (300) begin
         @(negedge sys_clk);
         cnt += int'(rate_tick_q === 1'h1 || baud_tick_q === 1'h1);
      end
      check_int(0, cnt);
   endtask

   // Mid-bit write must restart the prescaler, not keep its phase
   task automatic test_restart;
      int d;
      run_case(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, 1, 16);
      repeat (7) @(negedge sys_clk);
      // Rewrite as software would after a core clock change
      write_div(8'h00, 8'h00);
      d = 0;
      do begin
         @(negedge sys_clk);
         d++;
      end while (baud_tick_q !== 1'h1 && d < 100);
      check_int(16, d);
   endtask

   task automatic test_vote;
      int n;
      run_case(1'h0, 1'h1, 1'h1, 8'h00, 8'h00, 1, 4);
      line_level = 1'h0;
      glitch_en  = 1'h1;
      repeat (20) @(negedge sys_clk);
      repeat (3) begin
         gap(2, n);
         check_int(4, n);
         check_bit(1'h0, receive_level);
      end
      line_level = 1'h1;
      repeat (12) @(negedge sys_clk);
      gap(2, n);
      check_bit(1'h1, receive_level);
   endtask

   initial begin
      num_errors = 0;
      n_compared = 0;
      cycle_count = 0;
      reset_n = 1'h0;
      write_data = 8'h00;
      divisor_low_write = 1'h0;
      divisor_high_write = 1'h0;
      wide_counter_select = 1'h0;
      high_speed_select = 1'h0;
      sync_mode = 1'h0;
      clock_master = 1'h1;
      line_level = 1'h1;
      glitch_en = 1'h0;
      repeat (16) @(negedge sys_clk);
      check_bit(1'h0, rate_tick_q);
      check_bit(1'h0, baud_tick_q);
      check_bit(1'h1, receive_level);
      check_bit(1'h0, receive_level_valid);
      reset_n = 1'h1;
      @(negedge sys_clk);
      run_case(1'h0, 1'h0, 1'h0, 8'h00, 8'h02, 3, 192);
      run_case(1'h0, 1'h0, 1'h1, 8'h00, 8'h02, 3, 48);
      run_case(1'h0, 1'h1, 1'h0, 8'h01, 8'h02, 259, 4144);
      run_case(1'h0, 1'h0, 1'h0, 8'h01, 8'h02, 3, 192);
      run_case(1'h0, 1'h1, 1'h1, 8'h00, 8'h01, 2, 8);
      run_case(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, 1, 16);
      // Sync divisors kept at 2 or more
      run_case(1'h1, 1'h0, 1'h1, 8'h00, 8'h02, 3, 12);
      run_case(1'h1, 1'h1, 1'h0, 8'h01, 8'h02, 259, 1036);
      test_slave;
      test_restart;
      test_vote;
      report_and_stop;
   end
endmodule // testbench
